//--- pscm_defines.svh
// Constants for the pedal sensor correlation monitor.
// Assumes a 100 MHz core clock and 12-bit sensor samples.
`ifndef PSCM_DEFINES_SVH
`define PSCM_DEFINES_SVH
`define PSCM_CLK_PERIOD_NS 10
`define PSCM_RUN_MIN_S 10
`define PSCM_RUN_MIN_CYC (`PSCM_RUN_MIN_S * 64'h3B9ACA00 / `PSCM_CLK_PERIOD_NS)
`define PSCM_SETTLE_CYC 2'h3
`define PSCM_HIST_CYCLES 25
`define PSCM_FAULT_NUMBER 17'h1004D
`define PSCM_FAILURE_MODE 5'h02
`define PSCM_TOL_DEFAULT 12'h0CC
`define PSCM_ADC_W 12
`endif

//--- pscm_pkg.sv
// Types shared by the pedal sensor correlation monitor.
// Assumes nothing of its surroundings.
package pscm_pkg;
  typedef enum logic [1:0] {
    PSCM_IGN_OFF = 2'b00,
    PSCM_IGN_ON = 2'b01,
    PSCM_IGN_FAILED = 2'b10
  } pscm_ign_e;
endpackage : pscm_pkg

//--- pscm_sync.sv
// Two-flop synchroniser for a pin level.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/10ps
module pscm_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_q;
  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= '0;
      syncOut <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule : pscm_sync

//--- pscm_agree.sv
// Agreement test of the two opposite-going pedal sensors.
// Assumes samples are already synchronised to core_clk.
`timescale 1ns/10ps
`include "pscm_defines.svh"
module pscm_agree #(
  parameter int W = `PSCM_ADC_W
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] sensorA,
  input wire logic [W-1:0] sensorB,
  input wire logic [W-1:0] tolerance,
  output logic disagree_q
);
  // Sum of both readings spans full scale when they agree
  function automatic logic [W:0] absDiff(input logic [W:0] a, input logic [W:0] b);
    absDiff = (a > b) ? (a - b) : (b - a);
  endfunction : absDiff
  wire logic [W:0] sensorSum = {1'b0, sensorA} + {1'b0, sensorB};
  wire logic [W:0] fullScale = {1'b0, {W{1'b1}}};
  wire logic [W:0] error = absDiff(sensorSum, fullScale);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) disagree_q <= 1'b0;
    else disagree_q <= error > {1'b0, tolerance};
  end
endmodule : pscm_agree

//--- pscm_monitor.sv
// Pedal sensor correlation monitor: fault code, lamp, reduced power,
// idle throttle, and active/history fault clearing.
// Assumes sensor samples, ignition, engine-running and scan tool clear
// arrive as asynchronous levels; lever command is in core_clk domain.
`timescale 1ns/10ps
`include "pscm_defines.svh"
// How it works
// - Neutral lever is zero, rising away
// - Check runs with ignition, no 65581 fault
// - Disagreement sets fault 65613 mode 2
// - Lamp lights when check fails
// - Failure forces reduced power mode
// - Failure commands throttle to idle
// - Lever input ignored while faulted
// - Engine shutoff request under extra condition
// - Lamp holds for ignition cycle
// - Active fault clears on passing cycle
// - History clears after 25 long runs
// - Scan tool clear erases history
// - Check runs independently of others
module pscm_monitor #(
  parameter int W = `PSCM_ADC_W,
  parameter longint RUN_MIN_CYC = `PSCM_RUN_MIN_CYC,
  parameter int HIST_CYCLES = `PSCM_HIST_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] pedalSensorA,
  input wire logic [W-1:0] pedalSensorB,
  input wire logic [W-1:0] agreeTolerance,
  input wire logic ignitionOn,
  input wire logic engineRunning,
  input wire logic priorFaultSet,
  input wire logic scanToolClear,
  input wire logic shutoffCondition,
  input wire logic [W-1:0] leverCommand,
  output logic [W-1:0] pedalPosition,
  output logic [W-1:0] throttleCommand,
  output logic faultIndicatorLamp,
  output logic faultActive,
  output logic faultHistory,
  output logic [16:0] faultNumber,
  output logic [4:0] failureModeId,
  output logic reducedPower,
  output logic engineShutoff,
  output logic checkEnabled
);
  localparam logic [16:0] FAULT_NUM = `PSCM_FAULT_NUMBER;
  localparam logic [4:0] FAIL_MODE = `PSCM_FAILURE_MODE;

  // Synchronised pin levels
  logic [W-1:0] sensA, sensB;
  logic ignSync, runSync, priorSync, clrSync, offSync;
  pscm_sync #(.W(2 * W)) uSyncSens (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .asyncIn({pedalSensorA, pedalSensorB}),
    .syncOut({sensA, sensB})
  );
  pscm_sync #(.W(5)) uSyncCtl (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .asyncIn({ignitionOn, engineRunning, priorFaultSet, scanToolClear, shutoffCondition}),
    .syncOut({ignSync, runSync, priorSync, clrSync, offSync})
  );

  // Hold the check off until the compare holds real samples, since the
  // synchroniser reset value of both sensors reads as a disagreement
  localparam logic [1:0] SETTLE = `PSCM_SETTLE_CYC;
  logic [1:0] settle_q;
  wire logic settled = settle_q == SETTLE;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) settle_q <= 2'h0;
    else if (!settled) settle_q <= settle_q + 2'h1;
  end

  wire logic enable = ignSync && !priorSync && settled;
  logic disagree;
  pscm_agree #(.W(W)) uAgree (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sensorA(sensA),
    .sensorB(sensB),
    .tolerance(agreeTolerance),
    .disagree_q(disagree)
  );
  wire logic failNow = enable && disagree;
  wire logic passNow = enable && !disagree;

  // Ignition cycle tracking
  pscm_pkg::pscm_ign_e ign_q, ign_d;
  logic ignPrev_q;
  wire logic ignRise = ignSync && !ignPrev_q;
  wire logic ignFall = !ignSync && ignPrev_q;
  always_comb begin
    ign_d = ign_q;
    unique case (ign_q)
      pscm_pkg::PSCM_IGN_OFF: if (ignSync) ign_d = pscm_pkg::PSCM_IGN_ON;
      pscm_pkg::PSCM_IGN_ON: begin
        if (!ignSync) ign_d = pscm_pkg::PSCM_IGN_OFF;
        else if (failNow) ign_d = pscm_pkg::PSCM_IGN_FAILED;
      end
      pscm_pkg::PSCM_IGN_FAILED: if (!ignSync) ign_d = pscm_pkg::PSCM_IGN_OFF;
      default: ign_d = pscm_pkg::PSCM_IGN_OFF;
    endcase
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ign_q <= pscm_pkg::PSCM_IGN_OFF;
      ignPrev_q <= 1'b0;
    end else begin
      ign_q <= ign_d;
      ignPrev_q <= ignSync;
    end
  end

  // Lamp on at failure held until key off
  logic lamp_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) lamp_q <= 1'b0;
    else if (failNow) lamp_q <= 1'b1;
    else if (ignFall || !ignSync) lamp_q <= 1'b0;
  end

  // Active fault set on failure cleared on pass in later cycle
  logic active_q, passArm_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 1'b0;
      passArm_q <= 1'b0;
    end else begin
      if (ignRise) passArm_q <= active_q;
      else if (failNow) passArm_q <= 1'b0;
      if (failNow) active_q <= 1'b1;
      else if (passArm_q && passNow && ign_q == pscm_pkg::PSCM_IGN_ON) active_q <= 1'b0;
    end
  end

  // Run cycle timer: a run counts when it lasts the minimum time
  // Counter widths sized from the configured limits
  localparam int RUN_TW = $clog2(RUN_MIN_CYC + 1);
  localparam int HIST_TW = $clog2(HIST_CYCLES + 1);
  logic [RUN_TW-1:0] runTmr_q;
  logic runLong_q, runFail_q, runPrev_q;
  wire logic runEnd = runPrev_q && !runSync;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      runTmr_q <= '0;
      runLong_q <= 1'b0;
      runFail_q <= 1'b0;
      runPrev_q <= 1'b0;
    end else begin
      runPrev_q <= runSync;
      if (!runSync) begin
        runTmr_q <= '0;
        runLong_q <= 1'b0;
        runFail_q <= 1'b0;
      end else begin
        if (!runLong_q) runTmr_q <= runTmr_q + 1'b1;
        if (runTmr_q == RUN_TW'(RUN_MIN_CYC - 1)) runLong_q <= 1'b1;
        if (failNow) runFail_q <= 1'b1;
      end
    end
  end

  // History cleared after 25 clean long runs or scan tool
  logic history_q;
  logic [HIST_TW-1:0] clean_q;
  wire logic cleanRun = runEnd && runLong_q && !runFail_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      history_q <= 1'b0;
      clean_q <= '0;
    end else if (failNow) begin
      history_q <= 1'b1;
      clean_q <= '0;
    end else if (clrSync) begin
      history_q <= 1'b0;
      clean_q <= '0;
    end else if (runEnd && runFail_q) begin
      clean_q <= '0;
    end else if (cleanRun && history_q) begin
      if (clean_q == HIST_TW'(HIST_CYCLES - 1)) begin
        history_q <= 1'b0;
        clean_q <= '0;
      end else clean_q <= clean_q + 1'b1;
    end
  end

  // Position from rising sensor; idle and lever ignored
  wire logic faulted = active_q || failNow;
  logic [W-1:0] pos_q, thr_q;
  logic reduced_q, shut_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= '0;
      thr_q <= '0;
      reduced_q <= 1'b0;
      shut_q <= 1'b0;
    end else begin
      pos_q <= sensA;
      thr_q <= faulted ? '0 : leverCommand;
      reduced_q <= faulted;
      shut_q <= faulted && offSync;
    end
  end

  assign pedalPosition = pos_q;
  assign throttleCommand = thr_q;
  assign faultIndicatorLamp = lamp_q;
  assign faultActive = active_q;
  assign faultHistory = history_q;
  assign faultNumber = active_q ? FAULT_NUM : 17'h00000;
  assign failureModeId = active_q ? FAIL_MODE : 5'h00;
  assign reducedPower = reduced_q;
  assign engineShutoff = shut_q;
  assign checkEnabled = enable;

  chk_lamp_on_fail: assert property (@(posedge core_clk) disable iff (!arst_n)
    failNow |=> faultIndicatorLamp) else $error("lamp not lit after failure");
  chk_lamp_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    faultIndicatorLamp && ignSync |=> faultIndicatorLamp) else $error("lamp dropped in cycle");
  chk_enable_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!ignSync || priorSync) && !active_q |=> !faultActive) else $error("fault set while disabled");
  chk_fault_code: assert property (@(posedge core_clk) disable iff (!arst_n)
    faultActive |-> faultNumber == FAULT_NUM && failureModeId == FAIL_MODE) else $error("bad fault code");
  chk_throttle_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
    faulted |=> throttleCommand == '0) else $error("throttle follows lever");
  chk_reduced_pwr: assert property (@(posedge core_clk) disable iff (!arst_n)
    failNow |=> reducedPower) else $error("no reduced power");
  chk_shutoff_cond: assert property (@(posedge core_clk) disable iff (!arst_n)
    engineShutoff |-> $past(offSync) && $past(faulted)) else $error("shutoff without cause");
  chk_scan_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    clrSync && !failNow |=> !faultHistory) else $error("history kept after clear");
  // Active not cleared in failing cycle
  chk_active_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
    ign_q == pscm_pkg::PSCM_IGN_FAILED && ignSync && active_q |=> active_q) else $error("active cleared early");

  // Failure seen by an enabled check
  sequence seqFail;
    failNow;
  endsequence
  // Lamp, active fault, history and reduced power all in place
  sequence seqReact;
    faultIndicatorLamp && faultActive && faultHistory && reducedPower;
  endsequence
  // Key turned off after being on
  sequence seqKeyDrop;
    ignSync ##1 !ignSync;
  endsequence

  chk_fail_react: assert property (@(posedge core_clk) disable iff (!arst_n)
    seqFail |=> seqReact) else $error("fault reaction incomplete");
  chk_lamp_key_off: assert property (@(posedge core_clk) disable iff (!arst_n)
    seqKeyDrop |=> !faultIndicatorLamp) else $error("lamp lit after key off");
  chk_active_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    passArm_q && passNow && ign_q == pscm_pkg::PSCM_IGN_ON |=> !faultActive) else $error("active fault not cleared");
  chk_lever_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
    !faulted |=> throttleCommand == $past(leverCommand)) else $error("throttle ignores lever");
  chk_shutoff_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    faulted && offSync |=> engineShutoff) else $error("shutoff not commanded");
  chk_code_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
    !faultActive |-> faultNumber == 17'h00000 && failureModeId == 5'h00) else $error("code shown while inactive");
  chk_history_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    failNow |=> faultHistory) else $error("history not recorded");
  chk_history_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    faultHistory && !clrSync && !runEnd |=> faultHistory) else $error("history lost");
  chk_run_long: assert property (@(posedge core_clk) disable iff (!arst_n)
    runSync && !runLong_q && runTmr_q == RUN_TW'(RUN_MIN_CYC - 1) |=> runLong_q) else $error("long run missed");
  chk_hist_expire: assert property (@(posedge core_clk) disable iff (!arst_n)
    cleanRun && history_q && clean_q == HIST_TW'(HIST_CYCLES - 1) && !failNow && !clrSync |=> !faultHistory)
    else $error("history not aged out");
endmodule : pscm_monitor

//--- pscm_sensor_model.sv
// Partner model: two opposite-going pedal sensors with an injectable skew.
// Assumes the bench sets position and skew off the sampling edge.
`timescale 1ns/10ps
module pscm_sensor_model (
  input wire logic [11:0] position,
  input wire logic signed [12:0] skew,
  output logic [11:0] sensorRise,
  output logic [11:0] sensorFall
);
  assign sensorRise = position;
  assign sensorFall = 12'(13'sh0FFF - $signed({1'b0, position}) + skew);
endmodule : pscm_sensor_model

//--- tb_pedal_sensor_correlation_monitor.sv
// Self-checking bench for the pedal sensor correlation monitor.
// Assumes the monitor and the sensor model are compiled first.
`timescale 1ns/10ps
module tb_pedal_sensor_correlation_monitor;
  logic core_clk = 1'b0, arst_n = 1'b0, ign = 1'b1, run = 1'b0, prior = 1'b0, clr = 1'b0, shutCond = 1'b0;
  logic [11:0] pos = 12'h200, lever = 12'h000, tol = 12'h0CC, sensA, sensB, pedalPos, thr;
  logic signed [12:0] skew = 13'sh0000;
  logic lamp, active, hist, reduced, shut, enabled;
  logic [16:0] faultNum;
  logic [4:0] fmId;
  logic [31:0] r = 32'd83637;
  logic expAct = 1'b0;
  int fail_count = 0, compares = 0;
  pscm_sensor_model i_model (.position(pos), .skew(skew), .sensorRise(sensA), .sensorFall(sensB));
  pscm_monitor #(.RUN_MIN_CYC(20), .HIST_CYCLES(25)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .pedalSensorA(sensA), .pedalSensorB(sensB), .agreeTolerance(tol), .ignitionOn(ign),
    .engineRunning(run), .priorFaultSet(prior), .scanToolClear(clr), .shutoffCondition(shutCond),
    .leverCommand(lever), .pedalPosition(pedalPos), .throttleCommand(thr), .faultIndicatorLamp(lamp),
    .faultActive(active), .faultHistory(hist), .faultNumber(faultNum), .failureModeId(fmId),
    .reducedPower(reduced), .engineShutoff(shut), .checkEnabled(enabled));
  // Clock at 100 MHz
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr
  // Expected disagreement: sum off full scale by more than the band
  function automatic logic expBad(input logic signed [12:0] k);
    return (k > $signed({1'b0, tol})) || (k < -$signed({1'b0, tol}));
  endfunction : expBad
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step
  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] expv);
    compares++;
    if (seen !== expv) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, expv, seen);
    end
  endtask : chk
  // One engine run of a given length
  task automatic runCycle(input int len);
    run = 1'b1;
    step(len);
    run = 1'b0;
    step(6);
  endtask : runCycle
  task automatic tally_and_finish();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hang
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    step(5);
    arst_n = 1'b1;
    step(2);
    chk("lamp", lamp, 0);
    chk("active", active, 0);
    for (int i = 0; i < 20; i++) begin
      r = lfsr(r);
      pos = 12'h100 + {4'h0, r[7:0]} * 12'h00E;
      skew = r[16] ? -13'(r[15:8]) : 13'(r[15:8]);
      lever = r[27:16];
      expAct = expAct | expBad(skew);
      step(6);
      chk("pedalPosition", pedalPos, pos);
      chk("throttle", thr, expAct ? 12'h000 : lever);
      chk("active", active, expAct);
      chk("enabled", enabled, 1);
    end
    $display("random agreement done");
    skew = 13'sh0000;
    ign = 1'b0;
    step(6);
    ign = 1'b1;
    step(8);
    chk("active", active, 0);
    chk("lamp", lamp, 0);
    prior = 1'b1;
    skew = 13'sh0400;
    step(6);
    chk("enabled", enabled, 0);
    chk("active", active, 0);
    chk("faultNumber", faultNum, 17'h00000);
    prior = 1'b0;
    ign = 1'b0;
    step(6);
    chk("active", active, 0);
    chk("lamp", lamp, 0);
    skew = 13'sh0000;
    step(6);
    ign = 1'b1;
    step(6);
    $display("disable conditions done");
    shutCond = 1'b1;
    lever = 12'h7A5;
    for (int j = 0; j < 3; j++) begin
      skew = (j == 0) ? $signed({1'b0, tol}) : (j == 1) ? -$signed({1'b0, tol}) : $signed({1'b0, tol}) + 13'sd1;
      step(6);
      chk("active", active, expBad(skew));
    end
    chk("lamp", lamp, 1);
    chk("faultNumber", faultNum, 17'h1004D);
    chk("failureMode", fmId, 5'h02);
    chk("reduced", reduced, 1);
    chk("throttle", thr, 12'h000);
    chk("shutoff", shut, 1);
    chk("history", hist, 1);
    skew = 13'sh0000;
    shutCond = 1'b0;
    step(6);
    chk("shutoff", shut, 0);
    chk("lamp", lamp, 1);
    chk("throttle", thr, 12'h000);
    ign = 1'b0;
    step(6);
    chk("lamp", lamp, 0);
    ign = 1'b1;
    step(8);
    chk("lamp", lamp, 0);
    chk("active", active, 0);
    chk("throttle", thr, lever);
    chk("history", hist, 1);
    $display("fault set and clear done");
    for (int k = 0; k < 24; k++) runCycle(30);
    runCycle(5);
    chk("history", hist, 1);
    runCycle(30);
    chk("history", hist, 0);
    $display("history ageing done");
    skew = $signed({1'b0, tol}) + 13'sd1;
    step(6);
    skew = 13'sh0000;
    chk("history", hist, 1);
    clr = 1'b1;
    step(6);
    chk("history", hist, 0);
    clr = 1'b0;
    $display("scan clear done");
    tally_and_finish();
  end
endmodule : tb_pedal_sensor_correlation_monitor
